/* File: hdl/dbsp_pkg.sv */
// Purpose: shared constants and types of the debug serial port
// Assumes: 24-bit data words, 8-bit commands, 20 MHz core clock
// Notes: command byte is read flag, exit flag and register select
package dbsp_pkg;
   localparam int DATA_W = 24;
   localparam int SEL_W = 5;
   localparam int CNT_W = 5;
   localparam int CNT_LAST_CMD = 7;
   localparam int CNT_LAST_DATA = 23;
   localparam int CMD_READ_BIT = 7;
   localparam int CMD_EXIT_BIT = 6;
   localparam int BUF_W = SEL_W + DATA_W;
   localparam logic [CNT_W-1:0] LAST_CMD = CNT_W'(CNT_LAST_CMD);
   localparam logic [CNT_W-1:0] LAST_DATA = CNT_W'(CNT_LAST_DATA);
   localparam logic [CNT_W-1:0] TX_MSB = CNT_W'(DATA_W - 1);
   // acknowledge low time and pin turnaround time, in core cycles
   localparam logic [2:0] ACK_CYC = 3'h4;
   localparam logic [2:0] TURN_CYC = 3'h2;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   typedef enum logic [3:0]
   {
      ST_RUN = 4'h0,
      ST_HALT = 4'h1,
      ST_ACK = 4'h2,
      ST_DRWAIT = 4'h3,
      ST_CMD = 4'h4,
      ST_RDWAIT = 4'h5,
      ST_XFER = 4'h6,
      ST_WRBUF = 4'h7,
      ST_WRDONE = 4'h8,
      ST_TURN = 4'h9
   } dbsp_state_t;
endpackage

/* File: hdl/dbsp_port.sv */
// Purpose: debug serial port controller with status pin reuse
// Assumes: serial clock pin is a clock of its own; core signals on core_clk
// Notes: serial side is held in reset whenever its clock must be stopped
// Notes on behaviour
// RL1 - serial input is ignored unless the processor is in debug mode
// RL2 - commands and data shift in most significant bit first
// RL3 - outside debug mode the two input pins drive a two-bit chip status
// RL4 - a dual-purpose pin is tri-stated while it changes direction
// RL5 - during reset both dual-purpose pins are outputs driven low
// RL6 - input bits taken on serial clock fall, output bits launched on rise
// RL7 - controller keeps serial clock at or below an eighth of core clock
// RL8 - serial output carries the register chosen by the last command
// RL9 - output words start at the most significant bit, changing on rise
// RL10 - entering debug mode gives one low acknowledge pulse
// RL11 - after a read command a low pulse marks the data as ready
// RL12 - after a write command a low pulse marks readiness for data
// RL13 - after write data is written another low pulse follows
// RL14 - serial output is high during reset and when idle
// RL15 - debug request halts the core after its instruction, then debug mode
// RL16 - debug request in debug mode resynchronises the command state; a request falling in ST_ACK or ST_WRBUF is ignored here
// RL17 - request held through wait or stop until acknowledge, then debug mode
// RL18 - controller releases debug request before its first command
// RL19 - serial clock events and debug request are synchronised to core clock
`timescale 1ns/100ps
module dbsp_port
   import dbsp_pkg::*;
(
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // asynchronous reset, active high
   input wire logic debug_serial_clock, // serial clock pin, input side
   input wire logic debug_serial_in, // serial data pin, input side
   input wire logic debug_request_n, // debug request pin
   output logic chip_status_bit0, // status bit 0 pin drive
   output logic chip_status_bit0_oe_n, // status bit 0 pin enable
   output logic chip_status_bit1, // status bit 1 pin drive
   output logic chip_status_bit1_oe_n, // status bit 1 pin enable
   output logic debug_serial_out, // serial output pin
   input wire logic [1:0] core_status, // chip status from core
   output logic dbg_halt_req, // ask core to halt
   input wire logic core_halted, // core is halted in debug
   output logic rd_req, // register read request
   output logic [SEL_W-1:0] rd_sel, // register to read
   input wire logic [DATA_W-1:0] rd_data, // read data
   input wire logic rd_valid, // read data valid
   output logic wr_valid, // write word valid
   output logic [SEL_W-1:0] wr_sel, // register to write
   output logic [DATA_W-1:0] wr_data, // write data
   input wire logic wr_ready // core takes the write word
);

   dbsp_state_t state;
   dbsp_state_t ack_next;
   logic [2:0] cnt;
   logic link_hold;
   logic tx_hold;
   logic len_data;
   logic ack_low;
   logic rd_out;
   logic [DATA_W-1:0] tx_word;
   logic [BUF_W-1:0] wword;
   logic [SEL_W-1:0] sel;
   logic req_meta;
   logic req_sync;
   logic req_prev;
   logic req_fall;
   logic rx_meta;
   logic rx_sync;
   logic rx_seen;
   logic rx_new;
   logic in_cmd_phase;
   logic [CNT_W-1:0] rx_cnt;
   logic [DATA_W-1:0] rx_sr;
   logic [DATA_W-1:0] rx_word;
   logic rx_tgl;
   logic [CNT_W-1:0] tx_idx;
   logic tx_bit;
   logic [BUF_W-1:0] buf_mem [BUF_DEPTH];
   logic buf_wp;
   logic buf_rp;
   logic [1:0] buf_cnt;
   logic buf_in_ready;
   logic buf_push;
   logic buf_pop;

   // serial side: receive on the falling edge
   always_ff @(negedge debug_serial_clock or posedge link_hold) // [RL6]
   begin
      if (link_hold) // [RL1]
      begin
         rx_cnt <= '0;
         rx_sr <= '0;
         rx_word <= '0;
         rx_tgl <= 1'b0;
      end
      else
      begin
         rx_sr <= {rx_sr[DATA_W-2:0], debug_serial_in}; // [RL2]
         if (rx_cnt == (len_data ? LAST_DATA : LAST_CMD))
         begin
            rx_cnt <= '0;
            rx_word <= {rx_sr[DATA_W-2:0], debug_serial_in};
            rx_tgl <= ~rx_tgl;
         end
         else
         begin
            rx_cnt <= rx_cnt + CNT_W'(1);
         end
      end
   end

   // serial side: launch on the rising edge, msb first
   always_ff @(posedge debug_serial_clock or posedge tx_hold) // [RL6]
   begin
      if (tx_hold)
      begin
         tx_idx <= '0;
         tx_bit <= 1'b1;
      end
      else
      begin
         tx_bit <= tx_word[TX_MSB - tx_idx]; // [RL9]
         tx_idx <= tx_idx + CNT_W'(1);
      end
   end

   // request pin and word-done toggle into the core domain
   always_ff @(posedge core_clk or posedge sys_rst) // [RL19]
   begin
      if (sys_rst)
      begin
         req_meta <= 1'b1;
         req_sync <= 1'b1;
         req_prev <= 1'b1;
         rx_meta <= 1'b0;
         rx_sync <= 1'b0;
         rx_seen <= 1'b0;
      end
      else
      begin
         req_meta <= debug_request_n;
         req_sync <= req_meta;
         req_prev <= req_sync;
         rx_meta <= rx_tgl;
         rx_sync <= rx_meta;
         rx_seen <= rx_sync;
      end
   end

   assign req_fall = req_prev & ~req_sync;
   // word stays stable for many core cycles as the serial clock is slow
   assign rx_new = (rx_sync ^ rx_seen) & ~link_hold; // [RL7]
   assign in_cmd_phase = (state == ST_CMD) || (state == ST_RDWAIT) ||
                         (state == ST_XFER) || (state == ST_WRDONE);

   // two-entry write buffer toward the core
   assign buf_in_ready = (buf_cnt != BUF_DEPTH);
   assign buf_push = (state == ST_WRBUF) && buf_in_ready;
   assign buf_pop = wr_valid && wr_ready;
   assign wr_valid = (buf_cnt != 2'h0);
   assign wr_sel = buf_mem[buf_rp][BUF_W-1:DATA_W];
   assign wr_data = buf_mem[buf_rp][DATA_W-1:0];

   for (genvar i = 0; i < BUF_DEPTH; i++)
   begin : g_buf
      always_ff @(posedge core_clk or posedge sys_rst)
      begin
         if (sys_rst)
            buf_mem[i] <= '0;
         else if (buf_push && (buf_wp == 1'(i)))
            buf_mem[i] <= wword;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
         buf_cnt <= 2'h0;
      end
      else
      begin
         if (buf_push)
            buf_wp <= ~buf_wp;
         if (buf_pop)
            buf_rp <= ~buf_rp;
         if (buf_push && !buf_pop)
            buf_cnt <= buf_cnt + 2'h1;
         else if (buf_pop && !buf_push)
            buf_cnt <= buf_cnt - 2'h1;
      end
   end

   // status pins: driven low in reset, status when running, else inputs
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         chip_status_bit0 <= 1'b0; // [RL5]
         chip_status_bit1 <= 1'b0;
         chip_status_bit0_oe_n <= 1'b0;
         chip_status_bit1_oe_n <= 1'b0;
      end
      else
      begin
         chip_status_bit0 <= (state == ST_RUN) ? core_status[0] : 1'b0; // [RL3]
         chip_status_bit1 <= (state == ST_RUN) ? core_status[1] : 1'b0;
         chip_status_bit0_oe_n <= (state != ST_RUN) || !req_sync; // [RL4]
         chip_status_bit1_oe_n <= (state != ST_RUN) || !req_sync;
      end
   end

   assign debug_serial_out = ack_low ? 1'b0 : (rd_out ? tx_bit : 1'b1); // [RL14]
   assign rd_sel = sel;

   // command sequencer
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= ST_RUN;
         ack_next <= ST_RUN;
         cnt <= 3'h0;
         link_hold <= 1'b1;
         tx_hold <= 1'b1;
         len_data <= 1'b0;
         ack_low <= 1'b0;
         rd_out <= 1'b0;
         tx_word <= '0;
         wword <= '0;
         sel <= '0;
         dbg_halt_req <= 1'b0;
         rd_req <= 1'b0;
      end
      else if (in_cmd_phase && req_fall) // [RL16]
      begin
         link_hold <= 1'b1;
         tx_hold <= 1'b1;
         rd_out <= 1'b0;
         rd_req <= 1'b0;
         len_data <= 1'b0;
         ack_low <= 1'b1;
         cnt <= 3'h0;
         ack_next <= ST_DRWAIT;
         state <= ST_ACK;
      end
      else
      begin
         case (state)
            ST_RUN:
            begin
               if (!req_sync)
               begin
                  dbg_halt_req <= 1'b1; // [RL15]
                  state <= ST_HALT;
               end
            end
            ST_HALT:
            begin
               // request must stay low through wait or stop until halted
               if (core_halted) // [RL17]
               begin
                  ack_low <= 1'b1; // [RL10]
                  cnt <= 3'h0;
                  ack_next <= ST_DRWAIT;
                  state <= ST_ACK;
               end
            end
            ST_ACK:
            begin
               if (cnt == ACK_CYC - 3'h1)
               begin
                  ack_low <= 1'b0;
                  state <= ack_next;
               end
               cnt <= cnt + 3'h1;
            end
            ST_DRWAIT:
            begin
               if (req_sync) // [RL18]
               begin
                  link_hold <= 1'b0;
                  state <= ST_CMD;
               end
            end
            ST_CMD:
            begin
               if (rx_new)
               begin
                  sel <= rx_word[SEL_W-1:0]; // [RL8]
                  if (rx_word[CMD_EXIT_BIT])
                  begin
                     dbg_halt_req <= 1'b0;
                     link_hold <= 1'b1;
                     cnt <= 3'h0;
                     state <= ST_TURN;
                  end
                  else if (rx_word[CMD_READ_BIT])
                  begin
                     rd_req <= 1'b1;
                     len_data <= 1'b1;
                     state <= ST_RDWAIT;
                  end
                  else
                  begin
                     len_data <= 1'b1;
                     ack_low <= 1'b1; // [RL12]
                     cnt <= 3'h0;
                     ack_next <= ST_XFER;
                     state <= ST_ACK;
                  end
               end
            end
            ST_RDWAIT:
            begin
               if (rd_valid)
               begin
                  rd_req <= 1'b0;
                  tx_word <= rd_data; // [RL8]
                  tx_hold <= 1'b0;
                  rd_out <= 1'b1;
                  ack_low <= 1'b1; // [RL11]
                  cnt <= 3'h0;
                  ack_next <= ST_XFER;
                  state <= ST_ACK;
               end
            end
            ST_XFER:
            begin
               if (rx_new)
               begin
                  len_data <= 1'b0;
                  if (rd_out)
                  begin
                     rd_out <= 1'b0;
                     tx_hold <= 1'b1;
                     state <= ST_CMD;
                  end
                  else
                  begin
                     wword <= {sel, rx_word};
                     state <= ST_WRBUF;
                  end
               end
            end
            ST_WRBUF:
            begin
               if (buf_in_ready)
                  state <= ST_WRDONE;
            end
            ST_WRDONE:
            begin
               if (buf_cnt == 2'h0)
               begin
                  ack_low <= 1'b1; // [RL13]
                  cnt <= 3'h0;
                  ack_next <= ST_CMD;
                  state <= ST_ACK;
               end
            end
            ST_TURN:
            begin
               // pins stay released before status drive resumes
               if (cnt == TURN_CYC - 3'h1) // [RL4]
                  state <= ST_RUN;
               cnt <= cnt + 3'h1;
            end
            default:
            begin
               state <= ST_RUN;
            end
         endcase
      end
   end

endmodule // dbsp_port

/* File: verif/dbsp_port_properties.sv */
// Purpose: port-level assertions for the debug serial port
// Assumes: one core clock domain, asynchronous active-high reset
// Notes: bound to every dbsp_port instance
`timescale 1ns/100ps
module dbsp_port_properties
   import dbsp_pkg::*;
(
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // reset
   input wire logic debug_request_n, // request pin
   input wire logic [1:0] core_status, // core status
   input wire logic chip_status_bit0, // pin 0 value
   input wire logic chip_status_bit0_oe_n, // pin 0 enable
   input wire logic chip_status_bit1, // pin 1 value
   input wire logic chip_status_bit1_oe_n, // pin 1 enable
   input wire logic debug_serial_out, // serial out
   input wire logic dbg_halt_req, // halt request
   input wire logic core_halted, // core halted
   input wire logic rd_req, // read request
   input wire logic rd_valid, // read answer
   input wire logic wr_valid // write word held
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   sequence ack_low;
      !debug_serial_out [*4];
   endsequence
   sequence pins_off;
      chip_status_bit0_oe_n && chip_status_bit1_oe_n;
   endsequence
   a_reset_pins: assert property (disable iff (1'b0) sys_rst |-> debug_serial_out
      && !chip_status_bit0 && !chip_status_bit1 && !chip_status_bit0_oe_n && !chip_status_bit1_oe_n)
      else $error("pins wrong in reset");
   a_idle_high: assert property (!dbg_halt_req |-> debug_serial_out)
      else $error("serial out low while idle");
   a_halt_entry: assert property ($fell(debug_request_n) && !dbg_halt_req |-> ##[1:4] dbg_halt_req)
      else $error("no halt after request");
   a_entry_ack: assert property ($rose(core_halted) && dbg_halt_req |-> ##[1:3] !debug_serial_out)
      else $error("no ack on debug entry");
   a_ack_len: assert property ($fell(debug_serial_out) |-> ack_low)
      else $error("low pulse too short");
   a_pins_release: assert property ($rose(dbg_halt_req) |-> ##[0:2] pins_off)
      else $error("pins not released");
   a_pin_turnaround: assert property ($fell(dbg_halt_req) |-> pins_off [*2] ##[1:3] !chip_status_bit0_oe_n)
      else $error("turnaround wrong");
   a_status_follow: assert property (!$past(sys_rst) && !$past(chip_status_bit0_oe_n) && !chip_status_bit0_oe_n
      |-> {chip_status_bit1, chip_status_bit0} == $past(core_status)) else $error("status not shown");
   a_read_ack: assert property (rd_req && rd_valid |-> ##[1:3] !debug_serial_out)
      else $error("no ack after read");
   a_write_quiet: assert property (wr_valid |-> debug_serial_out)
      else $error("ack before word written");
endmodule // dbsp_port_properties
bind dbsp_port dbsp_port_properties u_props (.*);

/* File: verif/dbsp_host_model.sv */
// Purpose: behavioural host debugger on the serial debug pins
// Assumes: serial clock period 480 ns, low outside transfers
// Notes: drv is high while the host owns both shared pins
`timescale 1ns/100ps
module dbsp_host_model
   import dbsp_pkg::*;
(
   input wire logic core_clk, // bounds waits
   input wire logic debug_serial_out, // ack and data
   output logic sck, // serial clock
   output logic sdi, // serial data
   output logic debug_request_n, // request
   output logic drv // host drives pins
);
   localparam int HALF = 240;
   initial
   begin
      sck = 1'b0;
      sdi = 1'b0;
      debug_request_n = 1'b1;
      drv = 1'b0;
   end
   task automatic wait_ack(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 400 && !ok; i++)
      begin
         @(negedge core_clk);
         ok = !debug_serial_out;
      end
      repeat (6) @(posedge core_clk);
   endtask
   // data moves just after each fall; read bits taken at the fall
   task automatic shift(input int n, input logic [DATA_W-1:0] v, output logic [DATA_W-1:0] r);
      r = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         #5 sdi = v[i];
         #(HALF - 5) sck = 1'b1;
         #HALF r = {r[DATA_W-2:0], debug_serial_out};
         sck = 1'b0;
      end
      #5 sdi = ~sdi;
   endtask
   task automatic request(output logic ok);
      @(negedge core_clk) debug_request_n = 1'b0;
      wait_ack(ok);
      @(negedge core_clk) debug_request_n = 1'b1;
      drv = 1'b1;
      repeat (10) @(negedge core_clk);
   endtask
endmodule // dbsp_host_model

/* File: verif/debug_serial_port_tb.sv */
// Purpose: self-checking bench of the debug serial port
// Assumes: core side answers reads next cycle, writes with a set stall
// Notes: shared pins resolve with pull-downs when nobody drives
`timescale 1ns/100ps
module debug_serial_port_tb;
   import dbsp_pkg::*;
   typedef struct {logic [4:0] sel; logic [23:0] wv; int stall; logic [23:0] exp;} dbsp_row_t;
   dbsp_row_t rows[3] = '{'{5'h00, 24'hA5C3F0, 0, 24'hA5C3F0}, '{5'h1F, 24'h800001, 30, 24'h800001},
      '{5'h0A, 24'h5A5A5A, 2, 24'h5A5A5A}};
   logic core_clk = 1'b0, sys_rst = 1'b0, rd_valid = 1'b0, wr_ready = 1'b0, core_halted = 1'b0, ok;
   logic [1:0] core_status = 2'h2;
   logic [2:0] hd = 3'h0;
   logic [23:0] rd_data = 24'h0, last_wd, r;
   logic [23:0] regs [32];
   logic [4:0] last_ws, rd_sel, wr_sel;
   logic [23:0] wr_data;
   logic chip_status_bit0, chip_status_bit0_oe_n, chip_status_bit1, chip_status_bit1_oe_n, debug_serial_out;
   logic dbg_halt_req, rd_req, wr_valid, sck, sdi, debug_request_n, drv;
   int err_count = 0, n_compared = 0, cyc = 0, stall_cnt = 0;
   wire logic debug_serial_in = !chip_status_bit0_oe_n ? chip_status_bit0 : (drv ? sdi : 1'b0);
   wire logic debug_serial_clock = !chip_status_bit1_oe_n ? chip_status_bit1 : (drv ? sck : 1'b0);
   dbsp_port dut (.*);
   dbsp_host_model host (.*);
   always #25 core_clk = ~core_clk;
   task automatic wrap_up();
      if (err_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic rd(input logic [4:0] s, input logic [23:0] e);
      host.shift(8, {16'h0, 3'h4, s}, r);
      host.wait_ack(ok);
      chk("read ack", 24'(ok), 24'h1);
      host.shift(24, 24'h0, r);
      chk("read word", r, e);
   endtask
   // core side: halts 4 cycles after the request, answers reads next cycle
   always @(negedge core_clk)
   begin
      hd <= {hd[1:0], dbg_halt_req};
      core_halted <= hd[2];
      rd_valid <= rd_req && !rd_valid;
      rd_data <= regs[rd_sel];
      wr_ready <= (stall_cnt == 0);
      if (stall_cnt > 0)
         stall_cnt <= stall_cnt - 1;
      // wr_ready at the coming rising edge is the value set just above
      if (wr_valid && (stall_cnt == 0))
      begin
         regs[wr_sel] <= wr_data;
         last_wd <= wr_data;
         last_ws <= wr_sel;
      end
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         err_count++;
         wrap_up();
      end
   end
   initial
   begin
      // a real edge on reset, so the design's flops leave the unknown state
      #1 sys_rst = 1'b1;
      repeat (6) @(negedge core_clk);
      chk("reset pins", 24'({debug_serial_clock, debug_serial_in, debug_serial_out}), 24'h1);
      repeat (6) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (5) @(negedge core_clk);
      chk("run status", 24'({debug_serial_clock, debug_serial_in}), 24'h2);
      host.request(ok);
      chk("entry ack", 24'(ok), 24'h1);
      foreach (rows[i])
      begin
         host.shift(8, {19'h0, rows[i].sel}, r);
         host.wait_ack(ok);
         chk("write ack", 24'(ok), 24'h1);
         host.shift(24, rows[i].wv, r);
         stall_cnt = rows[i].stall;
         host.wait_ack(ok);
         chk("done ack", 24'(ok), 24'h1);
         chk("write word", last_wd, rows[i].exp);
         chk("write sel", 24'(last_ws), 24'(rows[i].sel));
         rd(rows[i].sel, rows[i].exp);
      end
      host.shift(3, 24'h5, r);
      host.request(ok);
      chk("resync ack", 24'(ok), 24'h1);
      rd(rows[0].sel, rows[0].exp);
      @(negedge core_clk) core_status = 2'h1;
      host.shift(8, 24'h40, r);
      host.drv = 1'b0;
      repeat (10) @(negedge core_clk);
      chk("exit status", 24'({dbg_halt_req, debug_serial_clock, debug_serial_in}), 24'h1);
      host.request(ok);
      chk("re-entry ack", 24'(ok), 24'h1);
      @(negedge core_clk) sys_rst = 1'b1;
      host.drv = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("mid reset", 24'({dbg_halt_req, debug_serial_clock, debug_serial_in, debug_serial_out}), 24'h1);
      sys_rst = 1'b0;
      repeat (5) @(negedge core_clk);
      chk("release status", 24'({debug_serial_clock, debug_serial_in}), 24'h1);
      wrap_up();
   end
endmodule // debug_serial_port_tb
